//--- verilog/hfis_irq_status.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Bit 16 sets on transmit status queue overflow; resets 0, write one clears.
// [R02] Bit 15 sets when a received frame reaches 2048 bytes; write one clears.
// [R03] Received frames of 2049 bytes or more keep only their first 2048 bytes.
// [R04] Bit 15 also sets when a tag pushes a 2044+ byte untagged frame over.
// [R05] Bit 14 sets on any receiver error; write one clears.
// [R06] Bit 13 sets on any transmitter error; write one clears.
// [R07] Bit 12 is read-only, follows pending general IO events from their source.
// [R08] Bit 10 sets on a write to a full transmit payload queue; write one clears.
// [R09] Bit 9 sets when transmit payload free space exceeds its threshold.
// [R10] Bit 8 sets when the transmit status queue becomes full.
// [R11] Bit 7 sets when transmit status occupancy reaches its threshold.
// [R12] Bit 6 sets on every dropped received frame; write one clears.
// [R13] Bit 4 sets on a status write into a full receive status queue.
// [R14] Bit 3 sets when receive status occupancy reaches its threshold.
// [R15] Flags record events regardless of enable; enables only gate the pin.
// [R16] Bits 11, 5, 2, 1 and 0 read zero and ignore writes.
module hfis_irq_status
    import hfis_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Receive byte stream into host MAC
    input wire logic rx_in_valid,
    input wire logic rx_in_last,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_tag_added,
    // Truncated receive stream
    output logic rx_out_valid,
    output logic rx_out_last,
    output logic [7:0] rx_out_data,
    // MAC event pulses
    input wire logic receiver_fault,
    input wire logic transmitter_fault,
    input wire logic rx_frame_discarded,
    // Queue events and levels
    input wire logic tx_status_queue_overflow,
    input wire logic tx_status_queue_full,
    input wire logic [7:0] tx_status_queue_used,
    input wire logic tx_payload_write,
    input wire logic tx_payload_full,
    input wire logic [7:0] tx_payload_free,
    input wire logic rx_status_write,
    input wire logic rx_status_queue_full,
    input wire logic [7:0] rx_status_queue_used,
    // General IO pending level from outside domain
    input wire logic general_io_event_source,
    // Enabled-and-pending summary toward the pin driver
    output logic irq_pending
);
    logic [31:0] interrupt_flag_status_reg;
    logic [31:0] interrupt_flag_status_next;
    logic [31:0] level_reg;
    logic [31:0] enable_reg;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] read_word;
    logic gpio_sync;
    logic oversize_pulse;
    logic [HFIS_LEN_W:0] tag_len_reg;
    logic tag_flag_reg;
    logic tag_oversize;
    logic txsq_full_d_reg;
    logic wr_status;

    // Write-one-to-clear helper for implemented sticky bits
    function automatic logic [31:0] hfis_w1c(input logic [31:0] cur,
                                            input logic [31:0] set,
                                            input logic [31:0] clr);
        hfis_w1c = ((cur & ~clr) | set) & HFIS_STATUS_MASK;
    endfunction : hfis_w1c

    // Field pick from level register
    function automatic logic [7:0] hfis_field(input logic [31:0] word, input int lsb);
        hfis_field = word[lsb +: 8];
    endfunction : hfis_field

    // General IO pending crosses from outside the clock domain
    hfis_sync hfis_sync_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(general_io_event_source),
        .sync_out(gpio_sync)
    );

    // Truncation and oversize detection of received frames
    hfis_rx_trunc hfis_rx_trunc_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(rx_in_valid),
        .in_last(rx_in_last),
        .in_data(rx_in_data),
        .out_valid(rx_out_valid),
        .out_last(rx_out_last),
        .out_data(rx_out_data),
        .oversize_pulse(oversize_pulse)
    );

    // Original length tracking of frames that receive an inserted tag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tag_len_reg <= '0;
            tag_flag_reg <= 1'b0;
        end else if (rx_in_valid && rx_in_last) begin
            tag_len_reg <= '0;
            tag_flag_reg <= 1'b0;
        end else if (rx_in_valid) begin
            if (tag_len_reg != '1) begin
                tag_len_reg <= tag_len_reg + 13'h0001;
            end
            tag_flag_reg <= tag_flag_reg | rx_in_tag_added;
        end
    end

    // Tagged frame whose pre-tag length was at least the tag limit
    assign tag_oversize = rx_in_valid && rx_in_last && (tag_flag_reg || rx_in_tag_added) &&
        ((tag_len_reg + 13'h0001) >= {1'b0, HFIS_TAG_LIMIT} + {1'b0, HFIS_TAG_BYTES}); // [R04]

    // Edge of transmit status queue full
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txsq_full_d_reg <= 1'b0;
        end else begin
            txsq_full_d_reg <= tx_status_queue_full;
        end
    end

    // Hardware set terms
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[HFIS_BIT_TXSQ_OVF] = tx_status_queue_overflow; // [R01]
        set_vec[HFIS_BIT_RX_OVERSIZE] = oversize_pulse | tag_oversize; // [R02] [R04]
        set_vec[HFIS_BIT_RX_FAULT] = receiver_fault; // [R05]
        set_vec[HFIS_BIT_TX_FAULT] = transmitter_fault; // [R06]
        set_vec[HFIS_BIT_TXPQ_OVR] = tx_payload_write && tx_payload_full; // [R08]
        set_vec[HFIS_BIT_TXPQ_SPACE] =
            tx_payload_free > hfis_field(level_reg, HFIS_LVL_TXA_LSB); // [R09]
        set_vec[HFIS_BIT_TXSQ_FULL] = tx_status_queue_full && !txsq_full_d_reg; // [R10]
        set_vec[HFIS_BIT_TXSQ_LEVEL] =
            tx_status_queue_used >= hfis_field(level_reg, HFIS_LVL_TXS_LSB); // [R11]
        set_vec[HFIS_BIT_RX_DISCARD] = rx_frame_discarded; // [R12]
        set_vec[HFIS_BIT_RXSQ_FULL] = rx_status_write && rx_status_queue_full; // [R13]
        set_vec[HFIS_BIT_RXSQ_LEVEL] =
            rx_status_queue_used >= hfis_field(level_reg, HFIS_LVL_RXS_LSB); // [R14]
    end

    // Software clear terms; general IO bit is not clearable here
    assign wr_status = reg_wr && (reg_addr == HFIS_STATUS_ADDR);
    assign clr_vec = wr_status ? (reg_wdata & ~(32'h0000_0001 << HFIS_BIT_GPIO)) : 32'h0000_0000;

    // Next status: sticky bits with set winning, plus live general IO bit
    always_comb begin
        interrupt_flag_status_next = hfis_w1c(interrupt_flag_status_reg, set_vec, clr_vec); // [R16]
        interrupt_flag_status_next[HFIS_BIT_GPIO] = gpio_sync; // [R07]
    end

    // Status flags update independent of enables
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_flag_status_reg <= HFIS_STATUS_RESET;
        end else begin
            interrupt_flag_status_reg <= interrupt_flag_status_next; // [R15]
        end
    end

    // Level thresholds and enables
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level_reg <= HFIS_LEVEL_RESET;
            enable_reg <= HFIS_ENABLE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == HFIS_LEVEL_ADDR) begin
                level_reg <= {8'h00, reg_wdata[23:0]};
            end
            if (reg_addr == HFIS_ENABLE_ADDR) begin
                enable_reg <= reg_wdata & HFIS_STATUS_MASK; // [R16]
            end
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            HFIS_STATUS_ADDR: read_word = interrupt_flag_status_reg & HFIS_STATUS_MASK; // [R16]
            HFIS_LEVEL_ADDR: read_word = level_reg;
            HFIS_INFO_ADDR: read_word = HFIS_STATUS_MASK;
            HFIS_ENABLE_ADDR: read_word = enable_reg;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // Read data one cycle after strobe, held only in that cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? read_word : 32'h0000_0000;
        end
    end

    // Pin summary: enables gate only this output
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_pending <= 1'b0;
        end else begin
            irq_pending <= |(interrupt_flag_status_next & enable_reg); // [R15]
        end
    end

    // Checks
    // Status queue overflow flag
    chk_overflow_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R01]
        tx_status_queue_overflow |=> interrupt_flag_status_reg[HFIS_BIT_TXSQ_OVF])
        else $error("overflow flag not set");

    // Oversize frame end
    chk_oversize_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R02]
        oversize_pulse |=> interrupt_flag_status_reg[HFIS_BIT_RX_OVERSIZE])
        else $error("oversize flag missing");

    // Tagged frame over the limit
    chk_tag_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R04]
        tag_oversize |=> interrupt_flag_status_reg[HFIS_BIT_RX_OVERSIZE])
        else $error("tag oversize flag missing");

    // No byte past the limit kept
    chk_trunc_len: assert property (@(posedge sys_clk) disable iff (!resetn) // [R03]
        (hfis_rx_trunc_inst.count_reg >= {1'b0, HFIS_FRAME_LIMIT}) && rx_in_valid
        |=> !rx_out_valid)
        else $error("byte past limit kept");

    // Last kept byte marked
    chk_last_mark: assert property (@(posedge sys_clk) disable iff (!resetn) // [R03]
        rx_in_valid && (hfis_rx_trunc_inst.count_reg == {1'b0, HFIS_FRAME_LIMIT} - 13'h0001)
        |=> rx_out_last)
        else $error("frame end mark missing");

    // Set wins over clear
    chk_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn) // [R05]
        (receiver_fault && wr_status && reg_wdata[HFIS_BIT_RX_FAULT])
        |=> interrupt_flag_status_reg[HFIS_BIT_RX_FAULT])
        else $error("set lost against clear");

    // Transmit fault flag
    chk_txfault_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
        transmitter_fault |=> interrupt_flag_status_reg[HFIS_BIT_TX_FAULT])
        else $error("transmit fault flag missing");

    // Write one clears
    chk_w1c_clears: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
        (wr_status && reg_wdata[HFIS_BIT_TX_FAULT] && !transmitter_fault)
        |=> !interrupt_flag_status_reg[HFIS_BIT_TX_FAULT])
        else $error("write one did not clear");

    // General IO bit trails its source
    chk_gpio_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // [R07]
        $rose(general_io_event_source) ##1 general_io_event_source[*2]
        |=> interrupt_flag_status_reg[HFIS_BIT_GPIO])
        else $error("general IO bit lag");

    // General IO bit ignores writes
    chk_gpio_ro: assert property (@(posedge sys_clk) disable iff (!resetn) // [R07]
        wr_status |=> interrupt_flag_status_reg[HFIS_BIT_GPIO] == $past(gpio_sync))
        else $error("general IO bit written");

    // Payload queue overrun
    chk_overrun_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
        (tx_payload_write && tx_payload_full) |=> interrupt_flag_status_reg[HFIS_BIT_TXPQ_OVR])
        else $error("payload overrun flag missing");

    // Payload space above threshold
    chk_space_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R09]
        (tx_payload_free > level_reg[HFIS_LVL_TXA_LSB +: 8])
        |=> interrupt_flag_status_reg[HFIS_BIT_TXPQ_SPACE])
        else $error("payload space flag missing");

    // Rising edge of queue full
    chk_full_edge: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
        $rose(tx_status_queue_full) |=> interrupt_flag_status_reg[HFIS_BIT_TXSQ_FULL])
        else $error("status queue full flag missing");

    // Transmit status level
    chk_txlevel_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
        (tx_status_queue_used >= level_reg[HFIS_LVL_TXS_LSB +: 8])
        |=> interrupt_flag_status_reg[HFIS_BIT_TXSQ_LEVEL])
        else $error("tx status level flag missing");

    // Dropped frame flag
    chk_drop_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R12]
        rx_frame_discarded |=> interrupt_flag_status_reg[HFIS_BIT_RX_DISCARD])
        else $error("discard flag missing");

    // Write into full receive status queue
    chk_rxsq_full: assert property (@(posedge sys_clk) disable iff (!resetn) // [R13]
        (rx_status_write && rx_status_queue_full)
        |=> interrupt_flag_status_reg[HFIS_BIT_RXSQ_FULL])
        else $error("rx status full flag missing");

    // Receive status level
    chk_rxlevel_set: assert property (@(posedge sys_clk) disable iff (!resetn) // [R14]
        (rx_status_queue_used >= level_reg[HFIS_LVL_RXS_LSB +: 8])
        |=> interrupt_flag_status_reg[HFIS_BIT_RXSQ_LEVEL])
        else $error("rx status level flag missing");

    // Summary low with enables off
    chk_gate_off: assert property (@(posedge sys_clk) disable iff (!resetn) // [R15]
        (enable_reg == 32'h0000_0000) |=> !irq_pending)
        else $error("summary raised while disabled");

    // Reserved state bits stay zero
    chk_rsvd_state: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
        (interrupt_flag_status_reg & ~HFIS_STATUS_MASK) == 32'h0000_0000)
        else $error("reserved state bit set");

    // Reserved bits read zero
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
        $past(reg_rd) && $past(reg_addr) == HFIS_STATUS_ADDR |-> reg_rdata[11] == 1'b0 &&
        reg_rdata[5] == 1'b0 && reg_rdata[2:0] == 3'b000)
        else $error("reserved bit nonzero");

    // Read data only after a read
    chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    // Main scenarios
    cov_oversize: cover property (@(posedge sys_clk) disable iff (!resetn)
        oversize_pulse ##1 interrupt_flag_status_reg[HFIS_BIT_RX_OVERSIZE]);
    cov_tag_over: cover property (@(posedge sys_clk) disable iff (!resetn) tag_oversize);
    cov_irq: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq_pending));
    cov_set_clear: cover property (@(posedge sys_clk) disable iff (!resetn)
        receiver_fault && wr_status && reg_wdata[HFIS_BIT_RX_FAULT]);
    cov_gpio_rise: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(interrupt_flag_status_reg[HFIS_BIT_GPIO]));
endmodule : hfis_irq_status

//--- shared/hfis_pkg.sv
package hfis_pkg;
    // Register map (word index scheme: byte address = 4 * index)
    localparam logic [7:0] HFIS_STATUS_ADDR = 8'h00;
    localparam logic [7:0] HFIS_LEVEL_ADDR = 8'h04;
    localparam logic [7:0] HFIS_INFO_ADDR = 8'h08;
    localparam logic [7:0] HFIS_ENABLE_ADDR = 8'h0C;
    // Status bit positions
    localparam int HFIS_BIT_TXSQ_OVF = 16;
    localparam int HFIS_BIT_RX_OVERSIZE = 15;
    localparam int HFIS_BIT_RX_FAULT = 14;
    localparam int HFIS_BIT_TX_FAULT = 13;
    localparam int HFIS_BIT_GPIO = 12;
    localparam int HFIS_BIT_TXPQ_OVR = 10;
    localparam int HFIS_BIT_TXPQ_SPACE = 9;
    localparam int HFIS_BIT_TXSQ_FULL = 8;
    localparam int HFIS_BIT_TXSQ_LEVEL = 7;
    localparam int HFIS_BIT_RX_DISCARD = 6;
    localparam int HFIS_BIT_RXSQ_FULL = 4;
    localparam int HFIS_BIT_RXSQ_LEVEL = 3;
    // Implemented bits of the status word
    localparam logic [31:0] HFIS_STATUS_MASK = 32'h0001_F7D8;
    localparam logic [31:0] HFIS_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] HFIS_ENABLE_RESET = 32'h0000_0000;
    // Frame length limits in bytes
    localparam logic [11:0] HFIS_FRAME_LIMIT = 12'h800;
    localparam logic [11:0] HFIS_TAG_LIMIT = 12'h7FC;
    localparam logic [11:0] HFIS_TAG_BYTES = 12'h004;
    // Level field layout: [7:0] rx status, [15:8] tx status, [23:16] tx space
    localparam int HFIS_LVL_RXS_LSB = 0;
    localparam int HFIS_LVL_TXS_LSB = 8;
    localparam int HFIS_LVL_TXA_LSB = 16;
    localparam logic [31:0] HFIS_LEVEL_RESET = 32'h0000_0000;
    // Frame truncation counter width
    localparam int HFIS_LEN_W = 12;
    typedef enum logic [1:0] {
        HFIS_RX_IDLE,
        HFIS_RX_KEEP,
        HFIS_RX_TRUNC
    } hfis_rx_state_type;
endpackage : hfis_pkg

//--- verilog/hfis_sync.sv
`timescale 1ns/1ps
module hfis_sync
    import hfis_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    // Two-stage synchroniser
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : hfis_sync

//--- verilog/hfis_rx_trunc.sv
`timescale 1ns/1ps
module hfis_rx_trunc
    import hfis_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Incoming byte stream
    input wire logic in_valid,
    input wire logic in_last,
    input wire logic [7:0] in_data,
    // Kept byte stream
    output logic out_valid,
    output logic out_last,
    output logic [7:0] out_data,
    // Frame ended at or beyond the limit
    output logic oversize_pulse
);
    logic [HFIS_LEN_W:0] count_reg;
    logic at_limit;

    assign at_limit = (count_reg >= {1'b0, HFIS_FRAME_LIMIT});

    // Byte counter per frame
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else if (in_valid && in_last) begin
            count_reg <= '0;
        end else if (in_valid && !at_limit) begin
            count_reg <= count_reg + 13'h0001;
        end
    end

    // Keep only first bytes up to the limit; last forced on final kept byte
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            out_last <= 1'b0;
            out_data <= 8'h00;
            oversize_pulse <= 1'b0;
        end else begin
            out_valid <= in_valid && !at_limit; // [R03]
            out_last <= in_valid && !at_limit && (in_last ||
                (count_reg == {1'b0, HFIS_FRAME_LIMIT} - 13'h0001)); // [R03]
            out_data <= in_data;
            oversize_pulse <= in_valid && in_last &&
                (count_reg >= {1'b0, HFIS_FRAME_LIMIT} - 13'h0001); // [R02]
        end
    end
endmodule : hfis_rx_trunc

//--- test/host_mac_fifo_irq_status_tb.sv
`timescale 1ns/1ps
module host_mac_fifo_irq_status_tb;
    import hfis_pkg::*;
    logic sys_clk, resetn, reg_wr, reg_rd, rx_in_valid, rx_in_last, rx_in_tag_added;
    logic [7:0] reg_addr, rx_in_data, tx_status_queue_used, tx_payload_free, rx_status_queue_used;
    logic [31:0] reg_wdata, reg_rdata;
    logic rx_out_valid, rx_out_last, irq_pending, receiver_fault, transmitter_fault;
    logic rx_frame_discarded, tx_status_queue_overflow, tx_status_queue_full, tx_payload_write;
    logic tx_payload_full, rx_status_write, rx_status_queue_full, general_io_event_source;
    logic [7:0] rx_out_data, last_data;
    int error_cnt = 0, check_count = 0, out_cnt, last_len;
    int ebit[17] = '{14, 13, 6, 16, 10, 4, 8, 7, 3, 9, -1, -1, -1, -1, -1, -1, -1};

    hfis_irq_status hfis_irq_status_inst (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_in_valid(rx_in_valid), .rx_in_last(rx_in_last),
        .rx_in_data(rx_in_data), .rx_in_tag_added(rx_in_tag_added),
        .rx_out_valid(rx_out_valid), .rx_out_last(rx_out_last), .rx_out_data(rx_out_data),
        .receiver_fault(receiver_fault), .transmitter_fault(transmitter_fault),
        .rx_frame_discarded(rx_frame_discarded),
        .tx_status_queue_overflow(tx_status_queue_overflow),
        .tx_status_queue_full(tx_status_queue_full), .tx_status_queue_used(tx_status_queue_used),
        .tx_payload_write(tx_payload_write), .tx_payload_full(tx_payload_full),
        .tx_payload_free(tx_payload_free), .rx_status_write(rx_status_write),
        .rx_status_queue_full(rx_status_queue_full), .rx_status_queue_used(rx_status_queue_used),
        .general_io_event_source(general_io_event_source), .irq_pending(irq_pending));

    // Clock, 5 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Counts kept bytes and notes where the frame end lands
    always @(posedge sys_clk) begin
        if (rx_out_valid) begin
            out_cnt <= out_cnt + 1;
            if (rx_out_last) begin
                last_len <= out_cnt + 1;
                last_data <= rx_out_data;
            end
        end
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is looked at only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, reg_rdata, exp);
    endtask : rdchk

    // Raises or drops the cause of one status event; k of 10 and up drives a near miss that sets no flag
    task automatic set_evt(input int k, input logic on);
        case (k)
            0: receiver_fault <= on;
            1: transmitter_fault <= on;
            2: rx_frame_discarded <= on;
            3: tx_status_queue_overflow <= on;
            4: begin tx_payload_write <= on; tx_payload_full <= on; end
            5: begin rx_status_write <= on; rx_status_queue_full <= on; end
            6: tx_status_queue_full <= on;
            7: tx_status_queue_used <= on ? 8'h10 : 8'h00;
            8: rx_status_queue_used <= on ? 8'h10 : 8'h00;
            9: tx_payload_free <= on ? 8'h81 : 8'h00;
            10: tx_status_queue_used <= on ? 8'h0F : 8'h00;
            11: rx_status_queue_used <= on ? 8'h0F : 8'h00;
            12: tx_payload_free <= on ? 8'h80 : 8'h00;
            13: tx_payload_full <= on;
            14: tx_payload_write <= on;
            15: rx_status_write <= on;
            default: rx_status_queue_full <= on;
        endcase
    endtask : set_evt

    task automatic send_frame(input int n, input logic tag, input logic [31:0] exp);
        out_cnt = 0;
        last_len = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rx_in_valid <= 1'b1;
            rx_in_data <= i[7:0];
            rx_in_last <= (i == n - 1);
            rx_in_tag_added <= tag;
        end
        @(posedge sys_clk);
        rx_in_valid <= 1'b0;
        rx_in_last <= 1'b0;
        rx_in_tag_added <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("kept bytes", out_cnt, (n > 2048) ? 2048 : n);
        chk("last position", last_len, (n > 2048) ? 2048 : n);
        chk("last byte", {24'h00_0000, last_data},
            ((n > 2048) ? 2047 : n - 1) & 32'h0000_00FF);
        rdchk(HFIS_STATUS_ADDR, exp, "oversize flag");
        wr(HFIS_STATUS_ADDR, 32'hFFFF_FFFF);
    endtask : send_frame

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the expected run of about 10.5k cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        {reg_wr, reg_rd, rx_in_valid, rx_in_last, rx_in_tag_added} = '0;
        {receiver_fault, transmitter_fault, rx_frame_discarded, tx_status_queue_overflow} = '0;
        {tx_status_queue_full, tx_payload_write, tx_payload_full, rx_status_write} = '0;
        {rx_status_queue_full, general_io_event_source} = '0;
        {reg_addr, rx_in_data, tx_status_queue_used, tx_payload_free, rx_status_queue_used} = '0;
        reg_wdata = '0;
        resetn = 1'b0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        // Zero thresholds make both occupancy flags true at once
        rdchk(HFIS_STATUS_ADDR, 32'h0000_0088, "status after reset");
        rdchk(HFIS_ENABLE_ADDR, 32'h0000_0000, "enable after reset");
        rdchk(HFIS_INFO_ADDR, HFIS_STATUS_MASK, "implemented bits");
        wr(HFIS_INFO_ADDR, 32'h0000_0000);
        rdchk(HFIS_INFO_ADDR, HFIS_STATUS_MASK, "implemented bits kept");
        rdchk(8'h10, 32'h0000_0000, "unmapped read");
        wr(HFIS_LEVEL_ADDR, 32'h0080_1010);
        rdchk(HFIS_LEVEL_ADDR, 32'h0080_1010, "level readback");
        wr(HFIS_STATUS_ADDR, 32'hFFFF_FFFF);
        rdchk(HFIS_STATUS_ADDR, 32'h0000_0000, "status cleared");
        $display("test reset_and_map done");
        // Each cause alone, then write-one clear
        for (int k = 0; k < 17; k++) begin
            @(posedge sys_clk);
            set_evt(k, 1'b1);
            @(posedge sys_clk);
            set_evt(k, 1'b0);
            rdchk(HFIS_STATUS_ADDR,
                (ebit[k] < 0) ? 32'h0 : 32'h0000_0001 << ebit[k], "event");
            wr(HFIS_STATUS_ADDR, 32'hFFFF_FFFF);
            rdchk(HFIS_STATUS_ADDR, 32'h0000_0000, "event cleared");
        end
        $display("test event_table done");
        // Flag latches while disabled; enable only gates the summary
        @(posedge sys_clk);
        receiver_fault <= 1'b1;
        wr(HFIS_STATUS_ADDR, 32'h0000_4000);
        rdchk(HFIS_STATUS_ADDR, 32'h0000_4000, "set beats clear");
        chk("summary disabled", {31'h0, irq_pending}, 32'h0);
        @(posedge sys_clk);
        receiver_fault <= 1'b0;
        wr(HFIS_ENABLE_ADDR, 32'hFFFF_FFFF);
        rdchk(HFIS_ENABLE_ADDR, HFIS_STATUS_MASK, "enable mask");
        chk("summary enabled", {31'h0, irq_pending}, 32'h1);
        wr(HFIS_STATUS_ADDR, 32'h0000_4000);
        repeat (2) @(posedge sys_clk);
        chk("summary cleared", {31'h0, irq_pending}, 32'h0);
        wr(HFIS_ENABLE_ADDR, 32'h0000_0000);
        $display("test enable_gating done");
        // General IO summary follows its source and ignores writes
        @(posedge sys_clk);
        general_io_event_source <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(HFIS_STATUS_ADDR, 32'h0000_1000);
        rdchk(HFIS_STATUS_ADDR, 32'h0000_1000, "io summary held");
        @(posedge sys_clk);
        general_io_event_source <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rdchk(HFIS_STATUS_ADDR, 32'h0000_0000, "io summary gone");
        $display("test general_io done");
        // Frame lengths around the limit, with and without an inserted tag
        send_frame(2047, 1'b0, 32'h0000_0000);
        send_frame(2048, 1'b0, 32'h0000_8000);
        send_frame(2050, 1'b0, 32'h0000_8000);
        send_frame(2048, 1'b1, 32'h0000_8000);
        send_frame(2047, 1'b1, 32'h0000_0000);
        $display("test frame_limit done");
        wrap_up();
    end
endmodule : host_mac_fifo_irq_status_tb
